//--- hdl/pmd_pkg.sv
// constants for the peripheral disable gate block
// assumes an apb slave on the instruction clock, one 32-bit word per register
//
// Behaviour
// - converter one is held off while bit 0 of disable register one is set, on while clear.
// - can controller one is held off while bit 1 of disable register one is set, on while clear.
// - bits 15 to 8 of disable register two are read/write capture unit disables, reset zero.
// - bits 7 to 0 of disable register two are read/write compare unit disables, reset zero.
// - a set disable bit stops all clocks of its unit and blocks its register writes.
// - a changed disable bit takes effect one instruction cycle after the write.
// - a unit is enabled only when its bit is clear and it is present; present units reset on.
package pmd_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  PMD_OFS_ONE   = 8'h00;
  localparam logic [7:0]  PMD_OFS_TWO   = 8'h04;
  localparam logic [15:0] PMD_RST_ONE   = 16'h0000;
  localparam logic [15:0] PMD_RST_TWO   = 16'h0000;
  localparam logic [1:0]  PMD_ONE_MASK  = 2'h3;
  localparam int          PMD_CONV_BIT  = 0;
  localparam int          PMD_CAN_BIT   = 1;
  localparam int          PMD_CAP_LSB   = 8;
  localparam int          PMD_CMP_LSB   = 0;
  localparam int          PMD_UNITS     = 8;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          PMD_DELAY_CYC = 1;
  // units built on this variant; absent units stay gated
  localparam logic [17:0] PMD_PRESENT   = 18'h3ffff;
endpackage : pmd_pkg

//--- hdl/pmd_gates.sv
// peripheral disable registers and per-unit clock enables
// assumes apb master on the same clock; gated units sit outside
`timescale 1ns/1ps
`default_nettype none
module pmd_gates
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             converter_one_en,
  output logic             can_one_en,
  output logic      [7:0]  capture_en,
  output logic      [7:0]  compare_en
);
  import pmd_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [1:0]  one_ff;
  logic [15:0] two_ff;
  logic [1:0]  nxt_one;
  logic [15:0] nxt_two;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;
  logic [17:0] en_ff;
  logic [17:0] nxt_en;
  logic        setup;
  logic        access;
  logic        hit_one;
  logic        hit_two;
  logic        pready_ff;
  logic        nxt_ready;

  // read data latched at the setup edge, so no wait state is needed
  assign setup   = psel && !penable;
  // writes wait for the access edge, where the master sees pready
  assign access  = psel && penable && pready_ff;
  assign hit_one = (paddr == PMD_OFS_ONE);
  assign hit_two = (paddr == PMD_OFS_TWO);

  always_comb
  begin
    nxt_one     = one_ff;
    nxt_two     = two_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (setup)
    begin
      nxt_pslverr = !(hit_one || hit_two);
      nxt_prdata  = 32'h0000_0000;
      if (!pwrite && hit_one)
        nxt_prdata[1:0] = one_ff;
      if (!pwrite && hit_two)
        nxt_prdata[15:0] = two_ff;
    end
    if (access && pwrite && hit_one)
      nxt_one = pwdata[1:0] & PMD_ONE_MASK;
    if (access && pwrite && hit_two)
      nxt_two = pwdata[15:0];
  end

  // enable is clear bit and present unit
  always_comb
  begin
    nxt_en = ~{two_ff, one_ff} & PMD_PRESENT;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      one_ff     <= PMD_RST_ONE[1:0];
      two_ff     <= PMD_RST_TWO;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      en_ff      <= PMD_PRESENT;
    end
    else
    begin
      one_ff     <= nxt_one;
      two_ff     <= nxt_two;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      en_ff      <= nxt_en;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // enables gate all unit clocks
  assign converter_one_en = en_ff[PMD_CONV_BIT];
  assign can_one_en       = en_ff[PMD_CAN_BIT];

  // ------------------------------------------------------------
  // per-unit gates
  // ------------------------------------------------------------
  for (genvar u = 0; u < PMD_UNITS; u++)
  begin : unit_g
    assign capture_en[u] = en_ff[PMD_CAP_LSB+2+u];
    assign compare_en[u] = en_ff[PMD_CMP_LSB+2+u];

    unit_cap_a: assert property (@(posedge clock) disable iff (!nrst)
      capture_en[u] == !$past(two_ff[PMD_CAP_LSB+u]))
      else $error("capture unit gate wrong");

    unit_cmp_a: assert property (@(posedge clock) disable iff (!nrst)
      compare_en[u] == !$past(two_ff[PMD_CMP_LSB+u]))
      else $error("compare unit gate wrong");

    unit_cap_delay_a: assert property (@(posedge clock) disable iff (!nrst)
      access && pwrite && hit_two |-> ##2 capture_en[u] == !$past(pwdata[PMD_CAP_LSB+u], 2))
      else $error("capture unit not one cycle late");

    unit_cmp_delay_a: assert property (@(posedge clock) disable iff (!nrst)
      access && pwrite && hit_two |-> ##2 compare_en[u] == !$past(pwdata[PMD_CMP_LSB+u], 2))
      else $error("compare unit not one cycle late");
  end : unit_g

  assign prdata           = prdata_ff;
  assign pslverr          = pslverr_ff;
  // pready rises at the first edge after reset and then stays high
  always_comb
  begin
    nxt_ready = 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pready_ff <= 1'b0;
    else
      pready_ff <= nxt_ready;
  end
  assign pready = pready_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // converter gate follows bit
  conv_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    converter_one_en == !$past(one_ff[0]))
    else $error("converter enable wrong");
  can_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    can_one_en == !$past(one_ff[1]))
    else $error("can enable wrong");
  cap_write_a: assert property (@(posedge clock) disable iff (!nrst)
    access && pwrite && hit_two |=> two_ff[15:8] == $past(pwdata[15:8]))
    else $error("capture bits not written");
  cmp_write_a: assert property (@(posedge clock) disable iff (!nrst)
    access && pwrite && hit_two |=> two_ff[7:0] == $past(pwdata[7:0]))
    else $error("compare bits not written");
  two_read_a: assert property (@(posedge clock) disable iff (!nrst)
    setup && !pwrite && hit_two |=> prdata[15:0] == $past(two_ff) && prdata[31:16] == 16'h0000)
    else $error("register two readback wrong");
  sequence wr_one_s;
    access && pwrite && hit_one;
  endsequence
  conv_delay_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_one_s |-> ##2 converter_one_en == !$past(pwdata[0], 2))
    else $error("disable not one cycle late");
  present_a: assert property (@(posedge clock) disable iff (!nrst)
    (en_ff & ~PMD_PRESENT) == 18'h00000)
    else $error("absent unit enabled");
  cap_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    capture_en == ~$past(two_ff[15:8]) && compare_en == ~$past(two_ff[7:0]))
    else $error("capture or compare gate wrong");
  // bad address answers error
  bad_addr_a: assert property (@(posedge clock) disable iff (!nrst)
    setup && !hit_one && !hit_two |=> pslverr && pready)
    else $error("unmapped address not flagged");

  // ------------------------------------------------------------
  // more checks
  // ------------------------------------------------------------
  sequence wr_two_s;
    access && pwrite && hit_two;
  endsequence

  sequence rd_one_s;
    setup && !pwrite && hit_one;
  endsequence

  // can gate one cycle after write
  can_delay_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_one_s |-> ##2 can_one_en == !$past(pwdata[1], 2))
    else $error("can disable not one cycle late");

  // gate unchanged in the write cycle
  gate_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_one_s |=> converter_one_en == $past(converter_one_en))
    else $error("gate moved too early");

  one_write_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_one_s |=> one_ff == $past(pwdata[1:0]))
    else $error("register one not written");

  one_read_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_one_s |=> prdata == {30'h0000_0000, $past(one_ff)})
    else $error("register one readback wrong");

  reg_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !(access && pwrite) |=> $stable(one_ff) && $stable(two_ff))
    else $error("register changed without write");

  gate_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
    !$past(access && pwrite) && !$past(access && pwrite, 2) |-> $stable(en_ff))
    else $error("gate changed without write");

  reset_val_a: assert property (@(posedge clock) disable iff (!nrst)
    !$past(nrst) |-> one_ff == PMD_RST_ONE[1:0] && two_ff == PMD_RST_TWO
      && en_ff == PMD_PRESENT)
    else $error("reset values wrong");

  // ready stays up once out of reset
  ready_up_a: assert property (@(posedge clock) disable iff (!nrst)
    $past(nrst) |-> pready)
    else $error("ready dropped");

  // mapped address answers without error
  good_addr_a: assert property (@(posedge clock) disable iff (!nrst)
    setup && (hit_one || hit_two) |=> !pslverr)
    else $error("mapped address flagged");

  // error only follows a setup edge
  err_cause_a: assert property (@(posedge clock) disable iff (!nrst)
    pslverr |-> $past(setup))
    else $error("error without request");

  upper_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");

  two_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_two_s |-> ##2 {capture_en, compare_en} == ~$past(pwdata[15:0], 2))
    else $error("register two gates wrong");
endmodule : pmd_gates
`default_nettype wire

//--- tb/pmd_gates_tb.sv
// bench for the disable gates: apb traffic against a register model
// assumes a zero-wait apb slave and enables that follow their bits a cycle late
`timescale 1ns/1ps
`default_nettype none
module pmd_gates_tb;
  import pmd_pkg::*;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr;
  logic        converter_one_en, can_one_en;
  logic [7:0]  paddr, capture_en, compare_en;
  logic [31:0] pwdata, prdata, rng;
  logic [15:0] r1, r2;
  logic [50:0] exp_q[$];
  logic [50:0] got;
  int          n_mismatch, n_tests;
  pmd_gates dut_u (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .converter_one_en, .can_one_en, .capture_en, .compare_en);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // ----------------------------------------
  // one transfer; expectation taken before the model updates
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic hit;
    hit = (a == PMD_OFS_ONE) || (a == PMD_OFS_TWO);
    exp_q.push_back({(a == PMD_OFS_ONE) ? {30'h0, r1[1:0]} : (a == PMD_OFS_TWO) ?
      {16'h0, r2} : 32'h0, ~hit, ~{r1[0], r1[1], r2}});
    if (wr && a == PMD_OFS_ONE) r1 = {14'h0, d[1:0]};
    if (wr && a == PMD_OFS_TWO) r2 = d[15:0];
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
  endtask : apb
  // ----------------------------------------
  // monitor; enables seen at a write's access edge are still the old ones
  // ----------------------------------------
  always @(posedge clock)
    if (psel && penable && pready)
    begin
      got = exp_q.pop_front();
      n_tests++;
      if ({pwrite ? got[50:19] : prdata, pslverr, converter_one_en, can_one_en, capture_en,
        compare_en} !== got)
      begin
        n_mismatch++;
        $display("Error %0t: transfer mismatch at address %h", $time, paddr);
      end
    end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    nrst = 1'b0;
    {r1, r2} = '0;
    rng = 32'h3772;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int p = 0; p < 2; p++)
    begin
      // reset reads, then all-ones writes with readback and unmapped accesses
      apb(1'b0, PMD_OFS_ONE, 32'h0);
      apb(1'b0, PMD_OFS_TWO, 32'h0);
      apb(1'b1, PMD_OFS_ONE, 32'hffffffff);
      apb(1'b1, PMD_OFS_TWO, 32'hffffffff);
      apb(1'b0, PMD_OFS_ONE, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      apb(1'b1, 8'h0c, 32'h0);
      apb(1'b0, PMD_OFS_TWO, 32'h0);
      $display("pattern pass %0d done", p);
      for (int i = 0; i < 60; i++)
      begin
        rng = xs(rng);
        apb(rng[3], (rng[1:0] == 2'h2) ? 8'h08 : {5'h0, rng[0], 2'h0}, rng);
      end
      $display("random pass %0d done", p);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
      // reset after each of the two passes turns every unit back on
      nrst <= 1'b0;
      #1;
      n_tests++;
      if ({converter_one_en, can_one_en, capture_en, compare_en} !== 18'h3ffff)
      begin
        n_mismatch++;
        $display("Error %0t: enables not on in reset", $time);
      end
      {r1, r2} = '0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
    end
    complete_run();
  end
endmodule : pmd_gates_tb
`default_nettype wire
